// ---- rtl/rtcca_pkg.sv ----
package rtcca_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] CLOCK_CONTROL_OFS    = 8'h00;
    localparam logic [7:0] ALARM_CONTROL_OFS    = 8'h10;
    localparam logic [7:0] TIME_VALUE_OFS       = 8'h20;
    localparam logic [7:0] DATE_VALUE_OFS       = 8'h30;
    localparam logic [7:0] ALARM_TIME_VALUE_OFS = 8'h40;
    localparam logic [7:0] ALARM_DATE_VALUE_OFS = 8'h50;

    // ------------------------------------------------------------------
    // clock_control field positions
    // ------------------------------------------------------------------
    localparam int CC_CAL_LSB      = 16;
    localparam int CC_ENABLE       = 15;
    localparam int CC_STOP_IDLE    = 13;
    localparam int CC_SRC_LSB      = 9;
    localparam int CC_OSEL_LSB     = 7;
    localparam int CC_RUNNING      = 6;
    localparam int CC_UNLOCK       = 3;
    localparam int CC_RIPPLE       = 2;
    localparam int CC_HALF_SECOND_FLAG      = 1;
    localparam int CC_PIN_OE       = 0;

    // ------------------------------------------------------------------
    // alarm_control field positions
    // ------------------------------------------------------------------
    localparam int AC_ARM          = 15;
    localparam int AC_CHIME        = 14;
    localparam int AC_PULSE        = 13;
    localparam int AC_RIPPLE       = 12;
    localparam int AC_INTV_LSB     = 8;

    // ------------------------------------------------------------------
    // Encodings, reset values and timing
    // ------------------------------------------------------------------
    localparam logic [1:0] SRC_LOWPOWER  = 2'h0;
    localparam logic [1:0] SRC_CRYSTAL   = 2'h1;
    localparam logic [1:0] OSEL_ALARM    = 2'h0;
    localparam logic [1:0] OSEL_SECONDS  = 2'h1;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [14:0] HALF_SEC_CNT = 15'h3FFF;
    localparam logic [14:0] SEC_LAST     = 15'h7FFF;
    localparam logic [14:0] RIPPLE_GUARD = 15'h0020;
    localparam logic [5:0]  MINUTE_LAST  = 6'h3B;

    // Alarm interval codes
    typedef enum logic [3:0] {
        RTCCA_IV_HALF  = 4'h0,
        RTCCA_IV_SEC   = 4'h1,
        RTCCA_IV_10SEC = 4'h2,
        RTCCA_IV_MIN   = 4'h3,
        RTCCA_IV_10MIN = 4'h4,
        RTCCA_IV_HOUR  = 4'h5,
        RTCCA_IV_DAY   = 4'h6,
        RTCCA_IV_WEEK  = 4'h7,
        RTCCA_IV_MONTH = 4'h8,
        RTCCA_IV_YEAR  = 4'h9
    } rtcca_interval_t;

endpackage

// ---- rtl/rtcca_top.sv ----
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Function
// - Signed 10-bit drift value adds or removes that many ticks per minute
// - Enable bit runs the calendar; writable only while unlocked
// - Stop-in-idle halts the calendar while the processor idles
// - Source field 01 crystal, 00 low-power oscillator, others reserved
// - Output select 01 seconds clock, 00 alarm pulse
// - Pin carries selected signal only while output enable is set
// - Running status shows a tick was seen from the selected reference; sticky until reset or a reserved source select
// - Unlock bit opens time and date registers; settable only after system unlock
// - Read ripple flag warns of rollover; software reads twice
// - Half-second flag tracks second half; seconds write clears it
// - Control and alarm control reset only on power-on reset
// - Arm bit auto-clears at event when count zero and no chime
// - Chime lets repeat count wrap 00 to FF; otherwise stops at 00
// - Pulse start level writable when disarmed; reads pulse when armed
// - Alarm ripple flag set within 32 ticks of half-second rollover
// - Interval codes 0 to 9 half-second up to year; rest reserved
// - Repeat count decrements on each event; n gives n+1 events
// - Time register holds BCD hours, minutes, seconds; low byte zero
// - Date register holds BCD year, month, day, weekday
// - Time and date writes ignored while unlock bit is clear
module rtcca_top
    import rtcca_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        por,
    input  wire logic        tick_crystal,
    input  wire logic        tick_lowpower,
    input  wire logic        cpu_idle,
    input  wire logic        sys_unlocked,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    output logic             clk_out,
    output logic             alarm_event
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Days in month for BCD month and year; leap every 4th year in range
    // Only the year modulo four matters,
    // so a narrow product that wraps is harmless
    function automatic logic [7:0] rtcca_month_days(input logic [7:0] mon,
                                                    input logic [7:0] yr);
        logic [4:0] ybin;
        ybin = 5'(yr[7:4] * 4'hA + yr[3:0]);
        case (mon)
            8'h02:   rtcca_month_days = (ybin[1:0] == 2'h0) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: rtcca_month_days = 8'h30;
            default: rtcca_month_days = 8'h31;
        endcase
    endfunction

    // Digits past the limit, even illegal ones,
    // fall straight to the wrap value
    // BCD increment with wrap to a given value past a limit
    function automatic logic [7:0] rtcca_bcd_inc(input logic [7:0] v,
                                                 input logic [7:0] lim,
                                                 input logic [7:0] wrap);
        if (v >= lim)
            rtcca_bcd_inc = wrap;
        else if (v[3:0] == 4'h9)
            rtcca_bcd_inc = {v[7:4] + 4'h1, 4'h0};
        else
            rtcca_bcd_inc = {v[7:4], v[3:0] + 4'h1};
    endfunction

    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------
    // Control fields; a plain reset keeps them
    logic [9:0]  cal_q;
    logic        en_q;
    logic        stop_idle_q;
    logic [1:0]  src_q;
    logic [1:0]  osel_q;
    logic        unlock_q;
    logic        pin_oe_q;
    // Alarm control and its compare values
    logic        arm_q;
    logic        chime_q;
    logic        pulse_q;
    logic [3:0]  intv_q;
    logic [7:0]  rpt_q;
    logic [31:0] atime_q;
    logic [23:0] adate_q;

    // Calendar digits, prescaler, drift state
    logic [7:0]  hr_q, min_q, sec_q;
    logic [7:0]  yr_q, mon_q, day_q;
    logic [3:0]  wday_q;
    logic [14:0] pre_q;
    logic [5:0]  min_tick_q;
    logic [9:0]  corr_q;
    logic        running_q;

    // Per-cycle strobes
    logic        tick, run, adv_tick, half_edge, sec_edge, min_edge;
    logic        time_wr, date_wr, alarm_wr, ctrl_wr, match, fire;
    logic        ripple_near;

    // ------------------------------------------------------------------
    // Tick selection and gating
    // ------------------------------------------------------------------
    // Reserved source codes give no ticks at all
    // Tick inputs are one-cycle pulses in this domain
    assign tick = (src_q == SRC_CRYSTAL)  ? tick_crystal :
                  (src_q == SRC_LOWPOWER) ? tick_lowpower : 1'b0;
    assign run  = en_q && !(stop_idle_q && cpu_idle);
    // Positive drift inserts extra ticks; negative swallows ticks
    assign adv_tick = run && (corr_q != 10'h000) && !cal_q[9]
                      ? 1'b1
                      : run && tick && !((corr_q != 10'h000) && cal_q[9]);
    // Strobe at the middle and at the end of a second
    assign half_edge = adv_tick
                       && (pre_q == HALF_SEC_CNT || pre_q == SEC_LAST);
    assign sec_edge  = adv_tick && (pre_q == SEC_LAST);
    assign min_edge  = sec_edge && (sec_q == 8'h59);

    // Write decodes; time and date registers shut while locked
    assign ctrl_wr  = wr && (addr == CLOCK_CONTROL_OFS);
    assign alarm_wr = wr && (addr == ALARM_CONTROL_OFS);
    assign time_wr  = wr && (addr == TIME_VALUE_OFS) && unlock_q;
    assign date_wr  = wr && (addr == DATE_VALUE_OFS) && unlock_q;

    // ------------------------------------------------------------------
    // Control register, power-on reset only
    // ------------------------------------------------------------------
    // A warm reset keeps the clock configured,
    // so software need not rebuild it
    always_ff @(posedge clk or posedge por) begin
        if (por) begin
            cal_q       <= CTRL_RESET[25:16];
            en_q        <= CTRL_RESET[CC_ENABLE];
            stop_idle_q <= CTRL_RESET[CC_STOP_IDLE];
            src_q       <= CTRL_RESET[10:9];
            osel_q      <= CTRL_RESET[8:7];
            unlock_q    <= CTRL_RESET[CC_UNLOCK];
            pin_oe_q    <= CTRL_RESET[CC_PIN_OE];
        end else if (ctrl_wr) begin
            cal_q       <= wdata[CC_CAL_LSB +: 10];
            stop_idle_q <= wdata[CC_STOP_IDLE];
            src_q       <= wdata[CC_SRC_LSB +: 2];
            osel_q      <= wdata[CC_OSEL_LSB +: 2];
            pin_oe_q    <= wdata[CC_PIN_OE];
            if (unlock_q)
                en_q <= wdata[CC_ENABLE];
            // Clearing always allowed; setting needs system unlock
            if (!wdata[CC_UNLOCK] || sys_unlocked)
                unlock_q <= wdata[CC_UNLOCK];
        end
    end

    // ------------------------------------------------------------------
    // Prescaler and drift correction
    // ------------------------------------------------------------------
    // Correction count loads once per minute, spent one tick at a time
    // Positive drift adds one advance per clock,
    // so it is spent within a few hundred cycles
    // A time write restarts the prescaler,
    // which also clears the half-second flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_q      <= 15'h0000;
            min_tick_q <= 6'h00;
            corr_q     <= 10'h000;
        end else begin
            if (time_wr)
                pre_q <= 15'h0000;
            else if (adv_tick)
                pre_q <= pre_q + 15'h0001;
            if (sec_edge)
                min_tick_q <= (min_tick_q == MINUTE_LAST) ? 6'h00
                                                          : min_tick_q + 6'h01;
            if (sec_edge && min_tick_q == MINUTE_LAST)
                corr_q <= cal_q[9] ? 10'(-cal_q) : cal_q;
            else if (corr_q != 10'h000 && run && (cal_q[9] ? tick : 1'b1))
                corr_q <= corr_q - 10'h001;
        end
    end

    // Running status: a tick seen from the chosen source since reset or a reserved source select
    // Sticky: a stopped oscillator is not seen,
    // which spares a timeout counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            running_q <= 1'b0;
        else if (tick)
            running_q <= 1'b1;
        else if (src_q != SRC_CRYSTAL && src_q != SRC_LOWPOWER)
            running_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Time and calendar
    // ------------------------------------------------------------------
    // Bus writes beat the carry chain;
    // a write on a second boundary drops one step
    // Carries test the digits before this update
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hr_q   <= 8'h00;
            min_q  <= 8'h00;
            sec_q  <= 8'h00;
            yr_q   <= 8'h00;
            mon_q  <= 8'h01;
            day_q  <= 8'h01;
            wday_q <= 4'h0;
        end else if (time_wr) begin
            hr_q  <= wdata[31:24];
            min_q <= wdata[23:16];
            sec_q <= wdata[15:8];
        end else if (date_wr) begin
            yr_q   <= wdata[31:24];
            mon_q  <= wdata[23:16];
            day_q  <= wdata[15:8];
            wday_q <= wdata[3:0];
        end else if (sec_edge) begin
            sec_q <= rtcca_bcd_inc(sec_q, 8'h59, 8'h00);
            if (min_edge) begin
                min_q <= rtcca_bcd_inc(min_q, 8'h59, 8'h00);
                if (min_q == 8'h59) begin
                    hr_q <= rtcca_bcd_inc(hr_q, 8'h23, 8'h00);
                    if (hr_q == 8'h23) begin
                        wday_q <= (wday_q >= 4'h6) ? 4'h0 : wday_q + 4'h1;
                        day_q  <= rtcca_bcd_inc(day_q,
                                      rtcca_month_days(mon_q, yr_q), 8'h01);
                        if (day_q >= rtcca_month_days(mon_q, yr_q)) begin
                            mon_q <= rtcca_bcd_inc(mon_q, 8'h12, 8'h01);
                            if (mon_q == 8'h12)
                                yr_q <= rtcca_bcd_inc(yr_q, 8'h99, 8'h00);
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Alarm match by interval mask
    // ------------------------------------------------------------------
    // Wider intervals compare more fields
    always_comb begin
        unique case (intv_q)
            RTCCA_IV_HALF:  match = 1'b1;
            RTCCA_IV_SEC:   match = (pre_q == SEC_LAST);
            RTCCA_IV_10SEC: match = sec_q[3:0] == atime_q[11:8];
            RTCCA_IV_MIN:   match = sec_q == atime_q[15:8];
            RTCCA_IV_10MIN: match = {min_q[3:0], sec_q} == atime_q[19:8];
            RTCCA_IV_HOUR:  match = {min_q, sec_q} == atime_q[23:8];
            RTCCA_IV_DAY:   match = {hr_q, min_q, sec_q} == atime_q[31:8];
            RTCCA_IV_WEEK:  match = {hr_q, min_q, sec_q} == atime_q[31:8]
                                    && wday_q == adate_q[3:0];
            RTCCA_IV_MONTH: match = {hr_q, min_q, sec_q} == atime_q[31:8]
                                    && day_q == adate_q[15:8];
            RTCCA_IV_YEAR:  match = {hr_q, min_q, sec_q} == atime_q[31:8]
                                    && {mon_q, day_q} == adate_q[23:8];
            default:        match = 1'b0;
        endcase
    end
    // Seconds-based matches look at the value that is just ending
    // Beyond one second, fire on whole seconds only
    assign fire = arm_q && half_edge && match && !(intv_q > 4'h1
                  && pre_q != SEC_LAST);

    // ------------------------------------------------------------------
    // Alarm control, power-on reset only
    // ------------------------------------------------------------------
    // An event outranks a bus write in one cycle,
    // so no decrement is ever lost; software
    // keeps out of the ripple window instead
    // Alarm time and date share this reset
    always_ff @(posedge clk or posedge por) begin
        if (por) begin
            arm_q   <= CTRL_RESET[AC_ARM];
            chime_q <= CTRL_RESET[AC_CHIME];
            pulse_q <= CTRL_RESET[AC_PULSE];
            intv_q  <= CTRL_RESET[11:8];
            rpt_q   <= CTRL_RESET[7:0];
            atime_q <= CTRL_RESET;
            adate_q <= CTRL_RESET[23:0];
        end else if (fire) begin
            pulse_q <= ~pulse_q;
            if (rpt_q != 8'h00 || chime_q)
                rpt_q <= rpt_q - 8'h01;
            if (rpt_q == 8'h00 && !chime_q)
                arm_q <= 1'b0;
        end else begin
            if (alarm_wr) begin
                arm_q   <= wdata[AC_ARM];
                chime_q <= wdata[AC_CHIME];
                intv_q  <= wdata[AC_INTV_LSB +: 4];
                rpt_q   <= wdata[7:0];
                if (!arm_q)
                    pulse_q <= wdata[AC_PULSE];
            end
            if (wr && addr == ALARM_TIME_VALUE_OFS)
                atime_q <= {wdata[31:8], 8'h00};
            if (wr && addr == ALARM_DATE_VALUE_OFS)
                adate_q <= {wdata[23:8], 4'h0, wdata[3:0]};
        end
    end

    // ------------------------------------------------------------------
    // Output pin and event
    // ------------------------------------------------------------------
    // Registered so the pin never glitches;
    // costs one cycle of lag
    // Reserved selects hold the pin low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_out     <= 1'b0;
            alarm_event <= 1'b0;
        end else begin
            alarm_event <= fire;
            if (!pin_oe_q)
                clk_out <= 1'b0;
            else if (osel_q == OSEL_SECONDS)
                clk_out <= pre_q[14];
            else if (osel_q == OSEL_ALARM)
                clk_out <= pulse_q;
            else
                clk_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    // Ripple window covers the last 32 ticks before each half-second
    // Both flags share it; meaningful only when on
    assign ripple_near = en_q && ((pre_q > HALF_SEC_CNT - RIPPLE_GUARD
                         && pre_q <= HALF_SEC_CNT)
                         || pre_q > SEC_LAST - RIPPLE_GUARD);

    // Zero outside the read cycle,
    // so slaves can be ORed onto one bus
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            rdata <= 32'h0000_0000;
        else if (rd) begin
            unique case (addr)
                CLOCK_CONTROL_OFS:
                    rdata <= {6'h00, cal_q, en_q, 1'b0, stop_idle_q, 2'h0,
                              src_q, osel_q, running_q, 2'h0, unlock_q,
                              ripple_near, pre_q[14], pin_oe_q};
                ALARM_CONTROL_OFS:
                    rdata <= {16'h0000, arm_q, chime_q, pulse_q,
                              ripple_near, intv_q, rpt_q};
                TIME_VALUE_OFS:
                    rdata <= {hr_q, min_q, sec_q, 8'h00};
                DATE_VALUE_OFS:
                    rdata <= {yr_q, mon_q, day_q, 4'h0, wday_q};
                ALARM_TIME_VALUE_OFS:
                    rdata <= atime_q;
                ALARM_DATE_VALUE_OFS:
                    rdata <= {8'h00, adate_q};
                default:
                    rdata <= 32'h0000_0000;
            endcase
        end else
            rdata <= 32'h0000_0000;
    end

endmodule

// ---- verification/rtcca_chk.sv ----
`timescale 1ns/1ps
module rtcca_chk
    import rtcca_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        por,
    input wire logic        tick_crystal,
    input wire logic        tick_lowpower,
    input wire logic        cpu_idle,
    input wire logic        sys_unlocked,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        clk_out,
    input wire logic        alarm_event
);
    // ------------------------------------------------------------------
    // Shadow of unlock, enable and pin enable
    // ------------------------------------------------------------------
    logic unl_q;
    logic en_q;
    logic oe_q;

    // Power-on only, so a plain reset leaves the shadow alone
    always_ff @(posedge clk or posedge por) begin
        if (por) begin
            unl_q <= 1'b0;
            en_q  <= 1'b0;
            oe_q  <= 1'b0;
        end else if (wr && addr == CLOCK_CONTROL_OFS) begin
            unl_q <= wdata[CC_UNLOCK] && (sys_unlocked || unl_q);
            oe_q  <= wdata[CC_PIN_OE];
            if (unl_q) begin
                en_q <= wdata[CC_ENABLE];
            end
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || por);

    sequence time_rd_s; rd && addr == TIME_VALUE_OFS; endsequence
    sequence date_rd_s; rd && addr == DATE_VALUE_OFS; endsequence
    sequence ctrl_rd_s; rd && addr == CLOCK_CONTROL_OFS; endsequence
    sequence alrm_rd_s; rd && addr == ALARM_CONTROL_OFS; endsequence
    sequence secs_wr_s; wr && addr == TIME_VALUE_OFS && unl_q; endsequence

    time_bcd_a: assert property (time_rd_s |=>
        rdata[7:0] == 8'h00 && rdata[31:28] <= 4'h2 && rdata[27:24] <= 4'h9
        && rdata[23:20] <= 4'h5 && rdata[19:16] <= 4'h9
        && rdata[15:12] <= 4'h5 && rdata[11:8] <= 4'h9)
        else $error("time value digits out of range");
    date_bcd_a: assert property (date_rd_s |=>
        rdata[7:4] == 4'h0 && rdata[3:0] <= 4'h6 && rdata[23:20] <= 4'h1
        && rdata[15:12] <= 4'h3 && rdata[11:8] <= 4'h9)
        else $error("date value digits out of range");
    half_second_flag_clear_a: assert property (secs_wr_s ##1 ctrl_rd_s |=>
        !rdata[CC_HALF_SECOND_FLAG])
        else $error("half second flag not cleared by seconds write");
    ctrl_bits_a: assert property (ctrl_rd_s |=>
        rdata[CC_ENABLE] == $past(en_q) && rdata[CC_UNLOCK] == $past(unl_q)
        && rdata[31:26] == 6'h00 && rdata[14] == 1'b0
        && rdata[12:11] == 2'h0 && rdata[5:4] == 2'h0)
        else $error("control enable or unlock readback wrong");
    alarm_resv_a: assert property (alrm_rd_s |=>
        rdata[31:16] == 16'h0000)
        else $error("alarm control upper half not zero");
    event_pulse_a: assert property (alarm_event |=> !alarm_event)
        else $error("alarm event longer than one cycle");
    pin_off_a: assert property (!oe_q [*2] |-> !clk_out)
        else $error("clock pin driven while output disabled");
    quiet_off_a: assert property (alarm_event |-> en_q)
        else $error("alarm event while calendar disabled");
endmodule

bind rtcca_top rtcca_chk u_chk (
    .clk(clk), .rst(rst), .por(por), .tick_crystal(tick_crystal),
    .tick_lowpower(tick_lowpower), .cpu_idle(cpu_idle),
    .sys_unlocked(sys_unlocked), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .clk_out(clk_out), .alarm_event(alarm_event)
);

// ---- verification/rtcca_top_test.sv ----
`timescale 1ns/1ps
module rtcca_top_test;
    import rtcca_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------------
    logic        clk          = 1'b0;
    logic        rst          = 1'b1;
    logic        por          = 1'b1;
    logic        tk           = 1'b0;
    logic        tk_lp        = 1'b0;
    logic        cpu_idle     = 1'b0;
    logic        sys_unlocked = 1'b0;
    logic [7:0]  addr         = 8'h00;
    logic [31:0] wdata        = 32'h0000_0000;
    logic        wr           = 1'b0;
    logic        rd           = 1'b0;
    logic [31:0] rdata;
    logic        clk_out;
    logic        alarm_event;
    int          n_fail       = 0;
    int          checked      = 0;
    int          cyc          = 0;
    int          n_evt        = 0;

    rtcca_top dut (
        .clk(clk), .rst(rst), .por(por), .tick_crystal(tk),
        .tick_lowpower(tk_lp), .cpu_idle(cpu_idle),
        .sys_unlocked(sys_unlocked), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .clk_out(clk_out), .alarm_event(alarm_event)
    );

    // 50 MHz
    always #10 clk = ~clk;

    // Event count and hang guard; ceiling sits above the ~86k-cycle plan
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (alarm_event === 1'b1) begin
            n_evt <= n_evt + 1;
        end
        if (cyc == 95000) begin
            n_fail = n_fail + 1;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    // Strobes are left high so a following access can be back to back
    task automatic acc(input logic w, input logic r, input logic [7:0] a,
                       input logic [31:0] d);
        wr    <= w;
        rd    <= r;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask

    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked = checked + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] e);
        acc(1'b0, 1'b1, a, 32'h0000_0000);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdata & m);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        @(posedge clk);
        // Running status is undefined on the low-power source, masked
        rchk("ctrl reset", CLOCK_CONTROL_OFS, 32'hFFFF_FFBF, 32'h0);
        rchk("alarm reset", ALARM_CONTROL_OFS, '1, 32'h0);
        rchk("time reset", TIME_VALUE_OFS, '1, 32'h0);
        rchk("date reset", DATE_VALUE_OFS, '1, 32'h0001_0100);
        rchk("unmapped", 8'h60, '1, 32'h0);
        // Locked: unlock, enable and time writes all refused
        wreg(CLOCK_CONTROL_OFS, 32'h0000_8008);
        wreg(TIME_VALUE_OFS, 32'h1234_5600);
        rchk("ctrl locked", CLOCK_CONTROL_OFS, 32'hFFFF_FFBF, 32'h0);
        rchk("time locked", TIME_VALUE_OFS, '1, 32'h0);
        sys_unlocked <= 1'b1;
        wreg(CLOCK_CONTROL_OFS, 32'h0200_0008);
        rchk("drift", CLOCK_CONTROL_OFS,
             32'hFFFF_FFBF, 32'h0200_0008);
        // Alarm set up while the calendar is off, so no ripple hazard
        wreg(ALARM_CONTROL_OFS, 32'h0000_2000);
        rchk("pulse start", ALARM_CONTROL_OFS, '1, 32'h0000_2000);
        wreg(ALARM_CONTROL_OFS, 32'h0000_8001);
        wreg(ALARM_CONTROL_OFS, 32'h0000_A001);
        rchk("pulse armed", ALARM_CONTROL_OFS, '1, 32'h0000_8001);
        // Enable, stop in idle, crystal source, alarm pulse on pin
        wreg(CLOCK_CONTROL_OFS, 32'h0000_A209);
        tk <= 1'b1;
        wreg(DATE_VALUE_OFS, 32'h9912_3106);
        cpu_idle <= 1'b1;
        wreg(TIME_VALUE_OFS, 32'h2359_5800);
        rchk("ctrl run", CLOCK_CONTROL_OFS, '1, 32'h0000_A249);
        idle(20000);
        rchk("idle flag", CLOCK_CONTROL_OFS, '1, 32'h0000_A249);
        rchk("idle time", TIME_VALUE_OFS, '1, 32'h2359_5800);
        cpu_idle <= 1'b0;
        idle(16500);
        rchk("half", CLOCK_CONTROL_OFS, '1, 32'h0000_A24B);
        rchk("first", ALARM_CONTROL_OFS, '1, 32'h0000_A000);
        chk("pin pulse", 32'h1, {31'h0, clk_out});
        chk("events one", 32'h1, 32'(n_evt));
        wreg(CLOCK_CONTROL_OFS, 32'h0000_A208);
        idle(3);
        chk("pin off", 32'h0, {31'h0, clk_out});
        idle(49300);
        rchk("rollover", TIME_VALUE_OFS, '1, 32'h0);
        rchk("new year", DATE_VALUE_OFS, '1, 32'h0001_0100);
        rchk("disarmed", ALARM_CONTROL_OFS, 32'hFFFF_DFFF, 32'h0);
        chk("events two", 32'h2, 32'(n_evt));
        // Plain reset keeps the control register
        rst <= 1'b1;
        idle(3);
        rst <= 1'b0;
        idle(1);
        rchk("ctrl kept", CLOCK_CONTROL_OFS,
             32'hFFFF_FFB9, 32'h0000_A208);
        tally_and_finish();
    end
endmodule
